/* adcgp_pkg.sv */
package adcgp_pkg;
	// register select codes
	localparam logic [2:0] REG_STATUS = 3'h0;
	localparam logic [2:0] REG_MODE = 3'h1;
	localparam logic [2:0] REG_CONFIG = 3'h2;
	localparam logic [2:0] REG_CONVERSION_RESULT = 3'h3;
	localparam logic [2:0] REG_PART_IDENTIFICATION = 3'h4;
	localparam logic [2:0] REG_GENERAL_OUTPUT_CONTROL = 3'h5;
	// communications byte fields
	localparam int COMM_WEN_BIT = 7;
	localparam int COMM_READ_BIT = 6;
	localparam int COMM_RS_LSB = 3;
	// mode register fields
	localparam int MODE_APPEND_BIT = 20;
	localparam logic [23:0] MODE_RESET = 24'h000000;
	// configuration register fields
	localparam int CFG_PSEUDO_BIT = 18;
	localparam int CFG_REFERENCE_BIT = 20;
	localparam int CFG_CHAN_TOP_LSB = 12;
	localparam logic [23:0] CONFIG_RESET = 24'h000000;
	// output control fields
	localparam int GPO_UPPER_EN_BIT = 5;
	localparam int GPO_LOWER_EN_BIT = 4;
	localparam logic [7:0] GPO_RESET = 8'h00;
	localparam logic [23:0] RESULT_RESET = 24'h000000;
	// transfer lengths in serial clocks
	localparam logic [5:0] LEN_COMM = 6'h08;
	localparam logic [5:0] LEN_BYTE = 6'h08;
	localparam logic [5:0] LEN_WORD = 6'h18;
	localparam logic [5:0] LEN_WORD_STATUS = 6'h20;
	typedef enum logic {
		ST_COMM = 1'b0,
		ST_DATA = 1'b1
	} adcgp_state_t;
endpackage

/* adcgp_regs.sv */
`timescale 1ns/1ps
module adcgp_regs import adcgp_pkg::*; #(
	parameter logic [7:0] ID_VALUE = 8'hA6 // arbitrary identification value
) (
	input wire logic ref_clk, // 10 MHz clock
	input wire logic rst, // async reset, high
	input wire logic sclk, // serial clock, idles high
	input wire logic cs_n, // serial select, low active
	input wire logic din, // serial data in
	output logic dout, // serial data out / ready
	output logic ready_n, // ready pin, low when result waits
	input wire logic conv_valid, // new result pulse
	input wire logic [23:0] conv_data, // new result
	output logic [3:0] pos_input_sel, // positive input code
	output logic neg_is_common, // negative input is common input
	output logic [3:0] gpo_out, // output pin levels
	output logic [3:0] gpo_oe, // output pin enables
	input wire logic [3:0] gpo_in, // output pin sensed levels
	output logic upper_pins_analog, // pins three, two as analog 1, 2
	output logic lower_pins_reference, // pins one, zero as second reference
	output logic lower_pins_analog // pins one, zero as analog 3, 4
);
	adcgp_state_t state_q;
	logic sclk_q;
	logic [5:0] cnt_q;
	logic [5:0] len_q;
	logic [2:0] rs_q;
	logic is_read_q;
	logic [22:0] rx_q;
	logic [31:0] tx_q;
	logic dout_q;
	logic ready_n_q;
	logic [23:0] mode_q;
	logic [23:0] config_q;
	logic [23:0] result_q;
	logic [3:0] tag_q;
	logic [7:0] gpo_q;
	logic rise;
	logic fall;
	logic [7:0] comm_byte;
	logic [23:0] wr_word;
	logic comm_done;
	logic data_done;
	logic read_done;
	logic [5:0] next_len;
	logic [31:0] read_val;
	logic [7:0] status_byte;
	logic [7:0] gpo_read;
	logic upper_en;
	logic lower_en;

	assign rise = sclk && !sclk_q && !cs_n;
	assign fall = !sclk && sclk_q && !cs_n;
	assign comm_byte = {rx_q[6:0], din};
	assign wr_word = {rx_q, din};
	assign comm_done = rise && state_q == ST_COMM && cnt_q == LEN_COMM - 6'h01
		&& !comm_byte[COMM_WEN_BIT];
	assign data_done = rise && state_q == ST_DATA && cnt_q == len_q - 6'h01;
	assign read_done = data_done && is_read_q && rs_q == REG_CONVERSION_RESULT;
	assign upper_en = gpo_q[GPO_UPPER_EN_BIT];
	assign lower_en = gpo_q[GPO_LOWER_EN_BIT];
	assign status_byte = {ready_n_q, 3'h0, tag_q};
	assign gpo_read = {gpo_q[7:4], upper_en ? gpo_in[3:2] : gpo_q[3:2],
		lower_en ? gpo_in[1:0] : gpo_q[1:0]};

	// shift register holds at most a result plus its status byte
	if (LEN_WORD_STATUS > 6'h20 || LEN_WORD > LEN_WORD_STATUS) begin : len_check
		$error("transfer lengths do not fit the shift register");
	end

	always_comb begin
		unique case (comm_byte[5:3])
			REG_STATUS, REG_PART_IDENTIFICATION, REG_GENERAL_OUTPUT_CONTROL: next_len = LEN_BYTE;
			REG_CONVERSION_RESULT: next_len = mode_q[MODE_APPEND_BIT] ? LEN_WORD_STATUS : LEN_WORD;
			default: next_len = LEN_WORD;
		endcase
	end

	// read value, left aligned so the top bit goes out first
	always_comb begin
		unique case (comm_byte[5:3])
			REG_STATUS: read_val = {status_byte, 24'h000000};
			REG_MODE: read_val = {mode_q, 8'h00};
			REG_CONFIG: read_val = {config_q, 8'h00};
			REG_CONVERSION_RESULT: read_val = {result_q, status_byte};
			REG_PART_IDENTIFICATION: read_val = {ID_VALUE, 24'h000000};
			REG_GENERAL_OUTPUT_CONTROL: read_val = {gpo_read, 24'h000000};
			default: read_val = 32'h00000000;
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sclk_q <= 1'b1;
		end else begin
			sclk_q <= sclk;
		end
	end

	// serial framing
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_COMM;
			cnt_q <= 6'h00;
			len_q <= LEN_BYTE;
			rs_q <= REG_STATUS;
			is_read_q <= 1'b0;
			rx_q <= 23'h000000;
		end else if (cs_n) begin
			state_q <= ST_COMM;
			cnt_q <= 6'h00;
		end else if (rise) begin
			rx_q <= wr_word[22:0];
			if (state_q == ST_COMM) begin
				if (cnt_q == LEN_COMM - 6'h01) begin
					cnt_q <= 6'h00;
					if (!comm_byte[COMM_WEN_BIT]) begin
						state_q <= ST_DATA;
						rs_q <= comm_byte[5:3];
						is_read_q <= comm_byte[COMM_READ_BIT];
						len_q <= next_len;
					end
				end else begin
					cnt_q <= cnt_q + 6'h01;
				end
			end else if (data_done) begin
				state_q <= ST_COMM;
				cnt_q <= 6'h00;
			end else begin
				cnt_q <= cnt_q + 6'h01;
			end
		end
	end

	// shift out on falling edges, ready level between frames
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tx_q <= 32'h00000000;
			dout_q <= 1'b1;
		end else if (comm_done && comm_byte[COMM_READ_BIT]) begin
			tx_q <= read_val;
		end else if (state_q == ST_DATA && is_read_q) begin
			if (fall) begin
				dout_q <= tx_q[31];
				tx_q <= {tx_q[30:0], 1'b0};
			end
		end else begin
			dout_q <= ready_n_q;
		end
	end

	// mode and configuration words, taken on the last data bit
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			mode_q <= MODE_RESET;
			config_q <= CONFIG_RESET;
		end else if (data_done && !is_read_q) begin
			if (rs_q == REG_MODE) begin
				mode_q <= wr_word;
			end
			if (rs_q == REG_CONFIG) begin
				config_q <= wr_word;
			end
		end
	end

	// host keeps bits 7 and 6 at zero
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			gpo_q <= GPO_RESET;
		end else if (data_done && !is_read_q && rs_q == REG_GENERAL_OUTPUT_CONTROL) begin
			gpo_q <= wr_word[7:0];
		end
	end

	// result and the channel it came from
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			result_q <= RESULT_RESET;
			tag_q <= 4'h0;
		end else if (conv_valid) begin
			result_q <= conv_data;
			tag_q <= pos_input_sel;
		end
	end

	// a new result wins over a finishing read
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ready_n_q <= 1'b1;
		end else if (conv_valid) begin
			ready_n_q <= 1'b0;
		end else if (read_done) begin
			ready_n_q <= 1'b1;
		end
	end

	// pin drive and pin function
	assign dout = dout_q;
	assign ready_n = ready_n_q;
	assign neg_is_common = config_q[CFG_PSEUDO_BIT];
	assign pos_input_sel = config_q[CFG_CHAN_TOP_LSB +: 4];
	assign gpo_oe = {upper_en, upper_en, lower_en, lower_en};
	assign gpo_out = {upper_en & gpo_q[3], upper_en & gpo_q[2],
		lower_en & gpo_q[1], lower_en & gpo_q[0]};
	assign upper_pins_analog = !upper_en;
	assign lower_pins_reference = config_q[CFG_REFERENCE_BIT];
	assign lower_pins_analog = !lower_en && !config_q[CFG_REFERENCE_BIT];

	// result, channel tag, ready and positive input select
	ready_after_read_a: assert property (@(posedge ref_clk) disable iff (rst)
		read_done && !conv_valid |=> ready_n ##1 dout)
		else $error("ready not raised after result read");
	result_load_a: assert property (@(posedge ref_clk) disable iff (rst)
		conv_valid |=> result_q == $past(conv_data) && !ready_n)
		else $error("result not loaded");
	channel_tag_a: assert property (@(posedge ref_clk) disable iff (rst)
		conv_valid |=> status_byte[3:0] == $past(pos_input_sel))
		else $error("channel tag wrong");
	positive_select_a: assert property (@(posedge ref_clk) disable iff (rst)
		neg_is_common |-> pos_input_sel == config_q[15:12])
		else $error("positive input select wrong");

	// serial framing, shift-out and output control write
	append_length_a: assert property (@(posedge ref_clk) disable iff (rst)
		comm_done && comm_byte[5:3] == REG_CONVERSION_RESULT |=>
		len_q == (mode_q[MODE_APPEND_BIT] ? LEN_WORD_STATUS : LEN_WORD))
		else $error("result length wrong");
	id_load_a: assert property (@(posedge ref_clk) disable iff (rst)
		comm_done && comm_byte[COMM_READ_BIT] && comm_byte[5:3] == REG_PART_IDENTIFICATION
		|=> tx_q[31:24] == ID_VALUE)
		else $error("identification not loaded");
	gpo_write_a: assert property (@(posedge ref_clk) disable iff (rst)
		data_done && !is_read_q && rs_q == REG_GENERAL_OUTPUT_CONTROL
		|=> gpo_q == $past(wr_word[7:0]))
		else $error("output control write lost");
	msb_first_a: assert property (@(posedge ref_clk) disable iff (rst)
		fall && state_q == ST_DATA && is_read_q && !(comm_done)
		|=> dout_q == $past(tx_q[31]))
		else $error("serial bit order wrong");

	// pin drive, pin function and readback
	upper_drive_a: assert property (@(posedge ref_clk) disable iff (rst)
		gpo_oe[3:2] == {2{gpo_q[5]}} && upper_pins_analog == !gpo_q[5])
		else $error("upper pin enable wrong");
	upper_value_a: assert property (@(posedge ref_clk) disable iff (rst)
		gpo_q[5] |-> gpo_out[3] == gpo_q[3] && gpo_out[2] == gpo_q[2])
		else $error("upper pin level wrong");
	lower_drive_a: assert property (@(posedge ref_clk) disable iff (rst)
		gpo_q[4] |-> gpo_oe[1:0] == 2'h3 && gpo_out[1:0] == gpo_q[1:0])
		else $error("lower pins not driven");
	lower_tristate_a: assert property (@(posedge ref_clk) disable iff (rst)
		!gpo_q[4] |-> gpo_oe[1:0] == 2'h0 && gpo_out[1:0] == 2'h0)
		else $error("lower pins not tristated");
	lower_function_a: assert property (@(posedge ref_clk) disable iff (rst)
		lower_pins_analog == (!gpo_q[4] && !config_q[CFG_REFERENCE_BIT])
		&& lower_pins_reference == config_q[CFG_REFERENCE_BIT])
		else $error("lower pin function wrong");
	gpo_readback_a: assert property (@(posedge ref_clk) disable iff (rst)
		gpo_q[5] |-> gpo_read[3:2] == gpo_in[3:2])
		else $error("readback not from pins");

	// held state between events
	ready_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
		!conv_valid && !read_done |=> ready_n == $past(ready_n))
		else $error("ready changed without cause");
	result_stable_a: assert property (@(posedge ref_clk) disable iff (rst)
		!conv_valid |=> result_q == $past(result_q))
		else $error("result changed without new conversion");
	tag_stable_a: assert property (@(posedge ref_clk) disable iff (rst)
		!conv_valid |=> tag_q == $past(tag_q))
		else $error("channel tag changed without new conversion");
	dout_ready_a: assert property (@(posedge ref_clk) disable iff (rst)
		state_q == ST_COMM && !(comm_done && comm_byte[COMM_READ_BIT])
		|=> dout == $past(ready_n))
		else $error("data pin does not show ready between frames");

	// words loaded for shift-out, shift advance and restart on deselect
	result_frame_a: assert property (@(posedge ref_clk) disable iff (rst)
		comm_done && comm_byte[COMM_READ_BIT] && comm_byte[5:3] == REG_CONVERSION_RESULT
		|=> tx_q == $past({result_q, status_byte}))
		else $error("result frame wrong");
	append_tail_a: assert property (@(posedge ref_clk) disable iff (rst)
		comm_done && comm_byte[5:3] == REG_CONVERSION_RESULT && mode_q[MODE_APPEND_BIT]
		|=> len_q == LEN_WORD_STATUS && tx_q[7:0] == $past(status_byte))
		else $error("status not appended to result");
	gpo_frame_a: assert property (@(posedge ref_clk) disable iff (rst)
		comm_done && comm_byte[COMM_READ_BIT] && comm_byte[5:3] == REG_GENERAL_OUTPUT_CONTROL
		|=> tx_q[31:24] == $past(gpo_read))
		else $error("output control frame wrong");
	status_frame_a: assert property (@(posedge ref_clk) disable iff (rst)
		comm_done && comm_byte[COMM_READ_BIT] && comm_byte[5:3] == REG_STATUS
		|=> tx_q[31:24] == $past(status_byte))
		else $error("status frame wrong");
	tx_shift_a: assert property (@(posedge ref_clk) disable iff (rst)
		fall && state_q == ST_DATA && is_read_q
		|=> tx_q == {$past(tx_q[30:0]), 1'b0})
		else $error("shift register not advanced");
	frame_restart_a: assert property (@(posedge ref_clk) disable iff (rst)
		cs_n |=> state_q == ST_COMM && cnt_q == 6'h00)
		else $error("frame not restarted on deselect");

	// register writes
	gpo_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
		!(data_done && !is_read_q && rs_q == REG_GENERAL_OUTPUT_CONTROL)
		|=> gpo_q == $past(gpo_q))
		else $error("output control changed without write");
	config_write_a: assert property (@(posedge ref_clk) disable iff (rst)
		data_done && !is_read_q && rs_q == REG_CONFIG |=> pos_input_sel ==
		$past(wr_word[CFG_CHAN_TOP_LSB +: 4]) && neg_is_common == $past(wr_word[CFG_PSEUDO_BIT]))
		else $error("channel selection not taken from write");
	mode_write_a: assert property (@(posedge ref_clk) disable iff (rst)
		data_done && !is_read_q && rs_q == REG_MODE
		|=> mode_q[MODE_APPEND_BIT] == $past(wr_word[MODE_APPEND_BIT]))
		else $error("append bit not taken from write");

	// pins and readback
	lower_readback_a: assert property (@(posedge ref_clk) disable iff (rst)
		gpo_q[GPO_LOWER_EN_BIT] |-> gpo_read[1:0] == gpo_in[1:0])
		else $error("lower readback not from pins");
	upper_stored_a: assert property (@(posedge ref_clk) disable iff (rst)
		!gpo_q[GPO_UPPER_EN_BIT] |-> gpo_read[3:2] == gpo_q[3:2])
		else $error("upper readback not from register");
	lower_stored_a: assert property (@(posedge ref_clk) disable iff (rst)
		!gpo_q[GPO_LOWER_EN_BIT] |-> gpo_read[1:0] == gpo_q[1:0])
		else $error("lower readback not from register");
	upper_quiet_a: assert property (@(posedge ref_clk) disable iff (rst)
		!gpo_q[GPO_UPPER_EN_BIT] |-> gpo_out[3:2] == 2'h0)
		else $error("upper pins driven while analog");
	reference_pin_a: assert property (@(posedge ref_clk) disable iff (rst)
		config_q[CFG_REFERENCE_BIT] |-> lower_pins_reference && !lower_pins_analog)
		else $error("lower pins not used as reference");
endmodule

/* adcgp_host.sv */
`timescale 1ns/1ps
module adcgp_host (
	input wire logic ref_clk, // bench clock
	output logic sclk, // serial clock, idles high
	output logic cs_n, // select, low active
	output logic din, // data to device
	input wire logic dout // data from device
);
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		din = 1'b0;
	end
	// comm byte then n data bits, msb first, four ref_clk cycles per phase
	task automatic xfer(input logic [7:0] comm, input int n, input logic [31:0] wd,
		output logic [31:0] rd);
		logic [39:0] sh;
		sh = {comm, wd << (32 - n)};
		rd = '0;
		@(posedge ref_clk);
		#1 cs_n = 1'b0;
		for (int i = 0; i < 8 + n; i++) begin
			repeat (4) @(posedge ref_clk);
			#1 sclk = 1'b0;
			din = sh[39 - i];
			repeat (4) @(posedge ref_clk);
			#1;
			if (i >= 8) rd = {rd[30:0], dout};
			sclk = 1'b1;
		end
		repeat (4) @(posedge ref_clk);
		#1 cs_n = 1'b1;
		// released line does not keep its last value
		din = ~din;
	endtask
endmodule

/* testbench.sv */
`timescale 1ns/1ps
module testbench;
	import adcgp_pkg::*;
	localparam logic [7:0] ID_TB = 8'h5C; // arbitrary identification value
	logic ref_clk, rst, sclk, cs_n, din, dout, ready_n, conv_valid, neg_is_common;
	logic upper_pins_analog, lower_pins_reference, lower_pins_analog;
	logic [23:0] conv_data, e;
	logic [3:0] pos_input_sel, gpo_out, gpo_oe, gpo_in, en;
	logic [31:0] rd;
	logic [7:0] gp;
	int fails, total_checks, cycles;
	int exp_q[$];
	adcgp_regs #(.ID_VALUE(ID_TB)) i_dut (.ref_clk(ref_clk), .rst(rst), .sclk(sclk),
		.cs_n(cs_n), .din(din), .dout(dout), .ready_n(ready_n), .conv_valid(conv_valid),
		.conv_data(conv_data), .pos_input_sel(pos_input_sel), .neg_is_common(neg_is_common),
		.gpo_out(gpo_out), .gpo_oe(gpo_oe), .gpo_in(gpo_in),
		.upper_pins_analog(upper_pins_analog), .lower_pins_reference(lower_pins_reference),
		.lower_pins_analog(lower_pins_analog));
	adcgp_host i_host (.ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 60000) begin
			fails++;
			finish_test();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic rdr(input logic [2:0] s, input int n);
		i_host.xfer({2'b01, s, 3'h0}, n, 32'h0, rd);
	endtask
	task automatic wrr(input logic [2:0] s, input int n, input logic [31:0] wd);
		i_host.xfer({2'b00, s, 3'h0}, n, wd, rd);
	endtask
	// pseudo mode on, channel code c, reference choice r
	task automatic setcfg(input logic [3:0] c, input logic r);
		wrr(REG_CONFIG, 24, {8'h0, 3'h0, r, 2'b01, 2'h0, c, 12'($urandom)});
		chk(pos_input_sel, c);
		chk(neg_is_common, 1'b1);
		chk(lower_pins_reference, r);
		chk(lower_pins_analog, !gp[4] && !r);
	endtask
	initial begin
		void'($urandom(24));
		rst = 1'b1;
		conv_valid = 1'b0;
		conv_data = 24'h000000;
		gpo_in = 4'h0;
		gp = 8'h00;
		repeat (8) @(posedge ref_clk);
		#1 rst = 1'b0;
		chk({gpo_oe, gpo_out, ready_n, upper_pins_analog}, 10'h003);
		chk({pos_input_sel, neg_is_common}, 5'h00);
		chk({lower_pins_reference, lower_pins_analog, dout}, 3'h3);
		wrr(REG_CONVERSION_RESULT, 24, $urandom);
		wrr(REG_PART_IDENTIFICATION, 8, $urandom);
		rdr(REG_CONVERSION_RESULT, 24);
		chk(rd, 32'h0);
		rdr(REG_PART_IDENTIFICATION, 8);
		chk(rd, ID_TB);
		rdr(REG_GENERAL_OUTPUT_CONTROL, 8);
		chk(rd, 32'h0);
		for (int c = 0; c < 16; c++) begin
			wrr(REG_MODE, 24, {8'h0, 3'h0, c[0], 20'h0});
			setcfg(c[3:0], 1'($urandom));
			@(posedge ref_clk);
			#1 conv_valid = 1'b1;
			conv_data = 24'($urandom);
			exp_q.push_back(conv_data);
			@(posedge ref_clk);
			#1 conv_valid = 1'b0;
			@(posedge ref_clk);
			#1;
			chk(ready_n, 1'b0);
			rdr(REG_STATUS, 8);
			chk(rd, {28'h0, c[3:0]});
			rdr(REG_CONVERSION_RESULT, c[0] ? 32 : 24);
			e = 24'(exp_q.pop_front());
			chk(rd, c[0] ? {e, 4'h0, c[3:0]} : {8'h0, e});
			chk({ready_n, dout}, 2'b11);
			rdr(REG_STATUS, 8);
			chk(rd, {24'h0, 4'h8, c[3:0]});
		end
		for (int k = 0; k < 12; k++) begin
			gp = 8'($urandom) & 8'h3F;
			gpo_in = 4'($urandom);
			wrr(REG_GENERAL_OUTPUT_CONTROL, 8, gp);
			setcfg(4'($urandom), 1'($urandom));
			en = {gp[5], gp[5], gp[4], gp[4]};
			chk(gpo_oe, en);
			chk(gpo_out, gp[3:0] & en);
			chk(upper_pins_analog, !gp[5]);
			rdr(REG_GENERAL_OUTPUT_CONTROL, 8);
			chk(rd, {gp[7:4], (gpo_in & en) | (gp[3:0] & ~en)});
		end
		// mid-run reset must bring every register back
		@(posedge ref_clk);
		#1 rst = 1'b1;
		repeat (2) @(posedge ref_clk);
		#1 rst = 1'b0;
		chk({gpo_oe, gpo_out, ready_n, upper_pins_analog}, 10'h003);
		chk({pos_input_sel, neg_is_common}, 5'h00);
		chk({lower_pins_reference, lower_pins_analog, dout}, 3'h3);
		rdr(REG_GENERAL_OUTPUT_CONTROL, 8);
		chk(rd, 32'h0);
		rdr(REG_CONVERSION_RESULT, 24);
		chk(rd, 32'h0);
		finish_test();
	end
endmodule
